/* File: core/rftxd_pkg.sv */
// Constants, types and helpers of the transmitter driver configuration block
package rftxd_pkg;

    localparam int unsigned ADDR_W = 10;
    localparam int unsigned REG_W = 8;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_DRV_MODE = 8'h28;
    localparam logic [7:0] IDX_AMP = 8'h29;
    localparam logic [7:0] IDX_MOD = 8'h2a;
    localparam logic [7:0] IDX_STATUS = 8'h30;

    // Driver mode fields
    localparam int unsigned DRV_INV2_BIT = 7;
    localparam int unsigned DRV_INV1_BIT = 6;
    localparam int unsigned DRV_ON_BIT = 3;
    localparam int unsigned DRV_STYLE_LSB = 0;
    localparam logic [7:0] DRV_MODE_MASK = 8'hcf;
    localparam logic [7:0] DRV_MODE_RST = 8'h00;

    // Amplitude fields
    localparam int unsigned AMP_RED_LSB = 6;
    localparam int unsigned AMP_RES_LSB = 0;
    localparam logic [7:0] AMP_MASK = 8'hdf;
    localparam logic [7:0] AMP_RST = 8'h00;

    // Modulation control fields
    localparam int unsigned MOD_GUARD_LSB = 4;
    localparam int unsigned MOD_MAX_BIT = 3;
    localparam int unsigned MOD_INV_BIT = 2;
    localparam int unsigned MOD_SEL_LSB = 0;
    localparam logic [7:0] MOD_MASK = 8'hff;
    localparam logic [7:0] MOD_RST = 8'h00;

    // Output drive styles; 3'h3 and 3'h6 are unsupported
    localparam logic [2:0] STYLE_HIZ = 3'h0;
    localparam logic [2:0] STYLE_OPEN_DRAIN = 3'h1;
    localparam logic [2:0] STYLE_PUSH_PULL = 3'h2;
    localparam logic [2:0] STYLE_FIX_LOW = 3'h4;
    localparam logic [2:0] STYLE_FIX_HIGH = 3'h5;

    // Modulation sources
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_ENVELOPE = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;

    // Carrier reductions below the driver supply, in millivolts
    localparam logic [15:0] RED_MV_0 = 16'h0064;
    localparam logic [15:0] RED_MV_1 = 16'h00fa;
    localparam logic [15:0] RED_MV_2 = 16'h01f4;
    localparam logic [15:0] RED_MV_3 = 16'h03e8;
    localparam logic [15:0] RED_MV_NONE = 16'h0000;

    typedef enum logic [1:0] {
        GS_IDLE = 2'b01,
        GS_GUARD = 2'b10
    } rftxd_guard_e;

    typedef struct packed {
        logic second_output_invert;
        logic first_output_invert;
        logic driver_outputs_on;
        logic [2:0] output_drive_style;
        logic [1:0] carrier_level_reduction;
        logic [4:0] residual_carrier_pct;
        logic [3:0] overshoot_guard_len;
        logic carrier_max_level;
        logic modulation_polarity_flip;
        logic [1:0] modulation_source_pick;
    } rftxd_cfg_s;

    typedef struct packed {
        logic level;
        logic oe;
    } rftxd_pin_s;

    function automatic logic [15:0] reduction_mv(input logic [1:0] code, input logic max_lvl);
        logic [15:0] mv;
        mv = RED_MV_NONE;
        if (!max_lvl) begin
            case (code)
                2'h0: mv = RED_MV_0;
                2'h1: mv = RED_MV_1;
                2'h2: mv = RED_MV_2;
                default: mv = RED_MV_3;
            endcase
        end
        return mv;
    endfunction : reduction_mv

endpackage : rftxd_pkg

/* File: core/rftxd_ahb_slave.sv */
// AHB-Lite slave front end: address phase capture and register strobes
`timescale 1ns/1ps
module rftxd_ahb_slave (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] idx_o,
    output logic [7:0] wdata_o
);
    logic act_ff;
    logic wr_ff;
    logic [7:0] idx_ff;
    logic ok_ff;

    // Stall while the block is frozen
    assign hreadyout_o = ce_i;
    assign hresp_o = 1'b0;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            act_ff <= 1'b0;
            wr_ff <= 1'b0;
            idx_ff <= 8'h00;
            ok_ff <= 1'b0;
        end else if (ce_i && hready_i) begin
            act_ff <= hsel_i && htrans_i[1];
            wr_ff <= hwrite_i;
            idx_ff <= haddr_i[rftxd_pkg::ADDR_W-1:2];
            ok_ff <= (haddr_i[31:rftxd_pkg::ADDR_W] == '0) && (haddr_i[1:0] == 2'h0)
                && (hsize_i == 3'h2);
        end
    end

    // Data phase ends on this edge when ce is high
    assign wr_o = ce_i && act_ff && wr_ff && ok_ff;
    assign rd_o = act_ff && !wr_ff && ok_ff;
    assign idx_o = idx_ff;
    assign wdata_o = hwdata_i[7:0];
endmodule : rftxd_ahb_slave

/* File: core/rftxd_pin_drv.sv */
// One transmitter pin output stage
`timescale 1ns/1ps
module rftxd_pin_drv (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic on_i,
    input wire logic [2:0] style_i,
    input wire logic invert_i,
    input wire logic sig_i,
    output rftxd_pkg::rftxd_pin_s pin_o
);
    logic lvl;

    assign lvl = sig_i ^ invert_i;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pin_o <= '0;
        end else if (ce_i) begin
            if (!on_i) begin
                pin_o <= '0;
            end else begin
                case (style_i)
                    rftxd_pkg::STYLE_OPEN_DRAIN: begin
                        pin_o.level <= 1'b0;
                        pin_o.oe <= !lvl;
                    end
                    rftxd_pkg::STYLE_PUSH_PULL: begin
                        pin_o.level <= lvl;
                        pin_o.oe <= 1'b1;
                    end
                    rftxd_pkg::STYLE_FIX_LOW: begin
                        pin_o.level <= 1'b0;
                        pin_o.oe <= 1'b1;
                    end
                    rftxd_pkg::STYLE_FIX_HIGH: begin
                        pin_o.level <= 1'b1;
                        pin_o.oe <= 1'b1;
                    end
                    default: begin
                        pin_o <= '0;
                    end
                endcase
            end
        end
    end
endmodule : rftxd_pin_drv

/* File: core/rftxd_top.sv */
// Transmitter driver configuration registers, modulation path and pin stages
// Functional notes
// [R1] - Driver mode bit 7 inverts what is driven on the second driver pin.
// [R2] - Driver mode bit 6 inverts what is driven on the first driver pin.
// [R3] - Driver mode bit 3 enables both driver pins together; when clear neither drives.
// [R4] - Driver mode bits 2..0 pick open drain, push-pull, high impedance, fixed high or low.
// [R5] - Software must not write drive style codes 3'h3 or 3'h6.
// [R6] - Amplitude bits 7..6 pick a carrier reduction of 100, 250, 500 or 1000 mV.
// [R7] - Amplitude bits 4..0 set the residual carrier percentage used while modulating.
// [R8] - Modulation bit 3 forces maximum carrier amplitude, overriding the reduction.
// [R9] - Modulation bits 7..4 give the overshoot guard length in carrier periods.
// [R10] - Modulation bit 2 inverts the modulation signal of the chosen source.
// [R11] - Modulation bits 1..0 pick no source, the internal envelope or the external input.
// [R12] - Reserved bits of driver mode and amplitude read zero and ignore writes.
`timescale 1ns/1ps
module rftxd_top (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic carrier_i,
    input wire logic internal_send_envelope_i,
    input wire logic external_signal_input_i,
    output logic first_driver_pin_o,
    output logic first_driver_pin_oe_o,
    output logic second_driver_pin_o,
    output logic second_driver_pin_oe_o,
    output logic modulating_o,
    output logic overshoot_guard_o,
    output logic [4:0] residual_carrier_pct_o,
    output logic [15:0] carrier_reduction_mv_o,
    output logic carrier_max_level_o
);
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] drv_mode_ff;
    logic [7:0] amp_ff;
    logic [7:0] mod_ff;
    rftxd_pkg::rftxd_cfg_s cfg;
    logic mod_src;
    logic nxt_mod;
    logic mod_sig_ff;
    logic carrier_prev_ff;
    logic carrier_rise;
    logic mod_rise;
    rftxd_pkg::rftxd_guard_e guard_st_ff;
    logic [3:0] guard_cnt_ff;
    rftxd_pkg::rftxd_pin_s pin1;
    rftxd_pkg::rftxd_pin_s pin2;
    logic [7:0] status;
    logic [7:0] rd_val;

    rftxd_ahb_slave u_bus (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hready_i(hready_i),
        .hwdata_i(hwdata_i),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .wr_o(wr),
        .rd_o(rd),
        .idx_o(idx),
        .wdata_o(wdata)
    );

    // Register storage, reserved bits held at zero
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            drv_mode_ff <= rftxd_pkg::DRV_MODE_RST;
            amp_ff <= rftxd_pkg::AMP_RST;
            mod_ff <= rftxd_pkg::MOD_RST;
        end else if (wr) begin
            case (idx)
                rftxd_pkg::IDX_DRV_MODE: drv_mode_ff <= wdata & rftxd_pkg::DRV_MODE_MASK; // [R12]
                rftxd_pkg::IDX_AMP: amp_ff <= wdata & rftxd_pkg::AMP_MASK; // [R12]
                rftxd_pkg::IDX_MOD: mod_ff <= wdata & rftxd_pkg::MOD_MASK;
                default: begin
                end
            endcase
        end
    end

    // Field views of the registers
    always_comb begin
        cfg.second_output_invert = drv_mode_ff[rftxd_pkg::DRV_INV2_BIT];
        cfg.first_output_invert = drv_mode_ff[rftxd_pkg::DRV_INV1_BIT];
        cfg.driver_outputs_on = drv_mode_ff[rftxd_pkg::DRV_ON_BIT];
        cfg.output_drive_style = drv_mode_ff[rftxd_pkg::DRV_STYLE_LSB +: 3];
        cfg.carrier_level_reduction = amp_ff[rftxd_pkg::AMP_RED_LSB +: 2];
        cfg.residual_carrier_pct = amp_ff[rftxd_pkg::AMP_RES_LSB +: 5];
        cfg.overshoot_guard_len = mod_ff[rftxd_pkg::MOD_GUARD_LSB +: 4];
        cfg.carrier_max_level = mod_ff[rftxd_pkg::MOD_MAX_BIT];
        cfg.modulation_polarity_flip = mod_ff[rftxd_pkg::MOD_INV_BIT];
        cfg.modulation_source_pick = mod_ff[rftxd_pkg::MOD_SEL_LSB +: 2];
    end

    // Source pick, reserved code behaves as no source
    always_comb begin
        case (cfg.modulation_source_pick)
            rftxd_pkg::SRC_ENVELOPE: mod_src = internal_send_envelope_i; // [R11]
            rftxd_pkg::SRC_EXTERNAL: mod_src = external_signal_input_i; // [R11]
            default: mod_src = 1'b0;
        endcase
    end

    // Polarity only applies when a source is picked
    always_comb begin
        nxt_mod = 1'b0;
        if (cfg.modulation_source_pick == rftxd_pkg::SRC_ENVELOPE
            || cfg.modulation_source_pick == rftxd_pkg::SRC_EXTERNAL) begin
            nxt_mod = mod_src ^ cfg.modulation_polarity_flip; // [R10]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mod_sig_ff <= 1'b0;
        end else if (ce_i) begin
            mod_sig_ff <= nxt_mod;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            carrier_prev_ff <= 1'b0;
        end else if (ce_i) begin
            carrier_prev_ff <= carrier_i;
        end
    end

    assign carrier_rise = carrier_i && !carrier_prev_ff;
    assign mod_rise = nxt_mod && !mod_sig_ff;

    // Overshoot guard: extra modulation counted in carrier periods
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            guard_st_ff <= rftxd_pkg::GS_IDLE;
            guard_cnt_ff <= 4'h0;
        end else if (ce_i) begin
            case (guard_st_ff)
                rftxd_pkg::GS_IDLE: begin
                    if (mod_rise && cfg.overshoot_guard_len != 4'h0) begin
                        guard_st_ff <= rftxd_pkg::GS_GUARD;
                        guard_cnt_ff <= cfg.overshoot_guard_len; // [R9]
                    end
                end
                rftxd_pkg::GS_GUARD: begin
                    if (carrier_rise) begin
                        guard_cnt_ff <= guard_cnt_ff - 4'h1; // [R9]
                        if (guard_cnt_ff == 4'h1) begin
                            guard_st_ff <= rftxd_pkg::GS_IDLE;
                        end
                    end
                end
                default: begin
                    guard_st_ff <= rftxd_pkg::GS_IDLE;
                    guard_cnt_ff <= 4'h0;
                end
            endcase
        end
    end

    assign overshoot_guard_o = (guard_st_ff == rftxd_pkg::GS_GUARD);
    assign modulating_o = mod_sig_ff || overshoot_guard_o;

    // Amplitude outputs
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            residual_carrier_pct_o <= 5'h00;
            carrier_reduction_mv_o <= rftxd_pkg::RED_MV_NONE;
            carrier_max_level_o <= 1'b0;
        end else if (ce_i) begin
            residual_carrier_pct_o <= cfg.residual_carrier_pct; // [R7]
            carrier_reduction_mv_o <= rftxd_pkg::reduction_mv(cfg.carrier_level_reduction,
                cfg.carrier_max_level); // [R6] [R8]
            carrier_max_level_o <= cfg.carrier_max_level; // [R8]
        end
    end

    // Pin stages
    rftxd_pin_drv u_pin1 (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .on_i(cfg.driver_outputs_on), // [R3]
        .style_i(cfg.output_drive_style), // [R4]
        .invert_i(cfg.first_output_invert), // [R2]
        .sig_i(carrier_i),
        .pin_o(pin1)
    );

    rftxd_pin_drv u_pin2 (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .on_i(cfg.driver_outputs_on), // [R3]
        .style_i(cfg.output_drive_style), // [R4]
        .invert_i(cfg.second_output_invert), // [R1]
        .sig_i(carrier_i),
        .pin_o(pin2)
    );

    assign first_driver_pin_o = pin1.level;
    assign first_driver_pin_oe_o = pin1.oe;
    assign second_driver_pin_o = pin2.level;
    assign second_driver_pin_oe_o = pin2.oe;

    assign status = {guard_cnt_ff, pin2.level, pin1.level, overshoot_guard_o, modulating_o};

    // Read mux, unmapped reads give zero
    always_comb begin
        case (idx)
            rftxd_pkg::IDX_DRV_MODE: rd_val = drv_mode_ff;
            rftxd_pkg::IDX_AMP: rd_val = amp_ff;
            rftxd_pkg::IDX_MOD: rd_val = mod_ff;
            rftxd_pkg::IDX_STATUS: rd_val = status;
            default: rd_val = 8'h00;
        endcase
    end

    assign hrdata_o = rd ? {24'h000000, rd_val} : 32'h00000000;

    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_mod_start;
        ce_i && mod_rise && cfg.overshoot_guard_len != 4'h0 && guard_st_ff == rftxd_pkg::GS_IDLE;
    endsequence

    sequence s_guard_loaded;
        overshoot_guard_o && guard_cnt_ff == $past(cfg.overshoot_guard_len);
    endsequence

    a_pins_off_idle: assert property ( // [R3]
        ce_i && !cfg.driver_outputs_on |=> !first_driver_pin_oe_o && !second_driver_pin_oe_o)
        else $error("Driver pin enabled while outputs are off");

    a_pin1_polarity: assert property ( // [R2]
        ce_i && cfg.driver_outputs_on && cfg.output_drive_style == rftxd_pkg::STYLE_PUSH_PULL
        |=> first_driver_pin_oe_o
            && first_driver_pin_o == ($past(carrier_i) ^ $past(cfg.first_output_invert)))
        else $error("First pin level does not follow carrier and invert");

    a_pin2_polarity: assert property ( // [R1]
        ce_i && cfg.driver_outputs_on && cfg.output_drive_style == rftxd_pkg::STYLE_PUSH_PULL
        |=> second_driver_pin_oe_o
            && second_driver_pin_o == ($past(carrier_i) ^ $past(cfg.second_output_invert)))
        else $error("Second pin level does not follow carrier and invert");

    a_style_fixed_high: assert property ( // [R4]
        ce_i && cfg.driver_outputs_on && cfg.output_drive_style == rftxd_pkg::STYLE_FIX_HIGH
        |=> first_driver_pin_o && first_driver_pin_oe_o && second_driver_pin_oe_o)
        else $error("Fixed high style not driving high");

    a_style_open_drain: assert property ( // [R4]
        ce_i && cfg.driver_outputs_on && cfg.output_drive_style == rftxd_pkg::STYLE_OPEN_DRAIN
        |=> !first_driver_pin_o && first_driver_pin_oe_o != $past(carrier_i ^ cfg.first_output_invert))
        else $error("Open drain pin drives high or at wrong phase");

    a_style_hiz: assert property ( // [R4]
        ce_i && cfg.output_drive_style == rftxd_pkg::STYLE_HIZ
        |=> !first_driver_pin_oe_o && !second_driver_pin_oe_o)
        else $error("High impedance style drives a pin");

    a_reduction_mv: assert property ( // [R6]
        ce_i && !cfg.carrier_max_level && cfg.carrier_level_reduction == 2'h3
        |=> carrier_reduction_mv_o == 16'h03e8)
        else $error("Largest reduction not applied");

    a_max_override: assert property ( // [R8]
        ce_i && cfg.carrier_max_level
        |=> carrier_max_level_o && carrier_reduction_mv_o == 16'h0000)
        else $error("Maximum amplitude does not override reduction");

    a_residual_pct: assert property ( // [R7]
        ce_i ##1 ce_i |=> residual_carrier_pct_o == $past(amp_ff[4:0], 2)
            || $past(wr, 2) || $past(wr))
        else $error("Residual carrier output lags its field");

    a_guard_load: assert property ( // [R9]
        s_mod_start |=> s_guard_loaded)
        else $error("Overshoot guard not loaded with its length");

    a_guard_holds: assert property ( // [R9]
        overshoot_guard_o && !(ce_i && carrier_rise) |=> overshoot_guard_o
            && guard_cnt_ff == $past(guard_cnt_ff))
        else $error("Overshoot guard moved without a carrier edge");

    a_mod_invert: assert property ( // [R10]
        ce_i && cfg.modulation_source_pick == rftxd_pkg::SRC_ENVELOPE
        |=> mod_sig_ff == $past(internal_send_envelope_i ^ cfg.modulation_polarity_flip))
        else $error("Envelope modulation polarity wrong");

    a_src_external: assert property ( // [R11]
        ce_i && cfg.modulation_source_pick == rftxd_pkg::SRC_EXTERNAL
        |=> mod_sig_ff == $past(external_signal_input_i ^ cfg.modulation_polarity_flip))
        else $error("External modulation not followed");

    a_src_none: assert property ( // [R11]
        ce_i && (cfg.modulation_source_pick == rftxd_pkg::SRC_NONE
            || cfg.modulation_source_pick == 2'h3) |=> !mod_sig_ff)
        else $error("Modulation present with no source");

    a_reserved_zero: assert property ( // [R12]
        rd && (idx == rftxd_pkg::IDX_DRV_MODE) |-> hrdata_o[5:4] == 2'h0 && hrdata_o[31:8] == '0)
        else $error("Reserved driver mode bits read nonzero");

    a_amp_reserved: assert property ( // [R12]
        rd && (idx == rftxd_pkg::IDX_AMP) |-> hrdata_o[5] == 1'b0)
        else $error("Reserved amplitude bit reads nonzero");

    a_pin2_open_drain: assert property ( // [R1]
        ce_i && cfg.driver_outputs_on && cfg.output_drive_style == rftxd_pkg::STYLE_OPEN_DRAIN
        |=> !second_driver_pin_o
            && second_driver_pin_oe_o != $past(carrier_i ^ cfg.second_output_invert))
        else $error("Second open drain pin drives high or at wrong phase");

    a_style_fixed_low: assert property ( // [R4]
        ce_i && cfg.driver_outputs_on && cfg.output_drive_style == rftxd_pkg::STYLE_FIX_LOW
        |=> !first_driver_pin_o && !second_driver_pin_o
            && first_driver_pin_oe_o && second_driver_pin_oe_o)
        else $error("Fixed low style not driving low");

    a_guard_count: assert property ( // [R9]
        overshoot_guard_o && ce_i && carrier_rise
        |=> guard_cnt_ff == $past(guard_cnt_ff) - 4'h1)
        else $error("Overshoot guard count not stepped on a carrier edge");

    a_guard_end: assert property ( // [R9]
        overshoot_guard_o && ce_i && carrier_rise && guard_cnt_ff == 4'h1
        |=> !overshoot_guard_o)
        else $error("Overshoot guard outlasts its length");

endmodule : rftxd_top

/* File: tb/rftxd_antenna_model.sv */
// Behavioural antenna circuit on the two driver pins
`timescale 1ns/1ps
module rftxd_antenna_model (
    input wire logic ref_clk_i,
    input wire logic tx1_level_i,
    input wire logic tx1_oe_i,
    input wire logic tx2_level_i,
    input wire logic tx2_oe_i,
    output logic tx1_line_o,
    output logic tx2_line_o
);
    logic last1 = 1'b0;
    logic last2 = 1'b0;
    // Released pin floats: shows the inverse of its last driven level
    always @(posedge ref_clk_i) begin
        if (tx1_oe_i) begin
            last1 <= tx1_level_i;
        end
        if (tx2_oe_i) begin
            last2 <= tx2_level_i;
        end
    end
    assign tx1_line_o = tx1_oe_i ? tx1_level_i : ~last1;
    assign tx2_line_o = tx2_oe_i ? tx2_level_i : ~last2;
endmodule : rftxd_antenna_model

/* File: tb/rftxd_tb.sv */
// Self-checking bench for the transmitter driver configuration block
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] A_DRV = {22'h0, rftxd_pkg::IDX_DRV_MODE, 2'b00};
    localparam logic [31:0] A_AMP = {22'h0, rftxd_pkg::IDX_AMP, 2'b00};
    localparam logic [31:0] A_MOD = {22'h0, rftxd_pkg::IDX_MOD, 2'b00};
    logic ref_clk_i, rst_i, ce_i, hsel, hwrite, hready, hresp, carrier, car_q, env, ext, run;
    logic p1, p1oe, p2, p2oe, l1, l2, modulating, guard, maxl, i1, i2, pk;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans, cdiv;
    logic [2:0] hsize;
    logic [4:0] pct;
    logic [15:0] mv;
    logic [2:0] styles [5];
    logic [15:0] red [4];
    logic [3:0] lens [2];
    int err_count, compares, n, cnt;

    rftxd_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .carrier_i(carrier), .internal_send_envelope_i(env),
        .external_signal_input_i(ext), .first_driver_pin_o(p1), .first_driver_pin_oe_o(p1oe),
        .second_driver_pin_o(p2), .second_driver_pin_oe_o(p2oe), .modulating_o(modulating),
        .overshoot_guard_o(guard), .residual_carrier_pct_o(pct),
        .carrier_reduction_mv_o(mv), .carrier_max_level_o(maxl));
    rftxd_antenna_model u_ant (.ref_clk_i(ref_clk_i), .tx1_level_i(p1), .tx1_oe_i(p1oe),
        .tx2_level_i(p2), .tx2_oe_i(p2oe), .tx1_line_o(l1), .tx2_line_o(l2));

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // Carrier of eight clock periods while running
    always @(posedge ref_clk_i) begin
        car_q <= carrier;
        if (run) begin
            cdiv <= cdiv + 2'h1;
            if (cdiv == 2'h3) begin
                carrier <= ~carrier;
            end
        end
    end

    task automatic end_of_test;
        $display("Compares %0d, errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk_i);
    endtask : cyc
    task automatic wait_rdy;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            err_count++;
            end_of_test();
        end
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        v = hrdata;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rdc(input logic [31:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0);
        chk(v, {24'h0, e});
        chk({31'h0, hresp}, 32'h0);
    endtask : rdc
    function automatic logic [1:0] pin_exp(input logic [2:0] s, input logic c, input logic iv);
        case (s)
            rftxd_pkg::STYLE_OPEN_DRAIN: return {~(c ^ iv), 1'b0};
            rftxd_pkg::STYLE_PUSH_PULL: return {1'b1, c ^ iv};
            rftxd_pkg::STYLE_FIX_LOW: return 2'b10;
            rftxd_pkg::STYLE_FIX_HIGH: return 2'b11;
            default: return 2'b00;
        endcase
    endfunction : pin_exp

    initial begin
        rst_i = 1'b1; ce_i = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; carrier = 1'b0; env = 1'b0; ext = 1'b0; run = 1'b0;
        cdiv = 2'h0; err_count = 0; compares = 0;
        styles = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5}; // Codes 3 and 6 never written
        red = '{16'h0064, 16'h00fa, 16'h01f4, 16'h03e8};
        lens = '{4'h1, 4'hf};
        cyc(5);
        rst_i <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            rdc(A_DRV, 8'h00);
            rdc(A_AMP, 8'h00);
            rdc(A_MOD, 8'h00);
            rdc(32'h0000_0100, 8'h00);
            rdc(32'h0000_00c0, 8'h00);
            wr(A_DRV, 8'hff);
            rdc(A_DRV, 8'hcf);
            ce_i <= 1'b0;
            fork
                begin
                    cyc(3);
                    ce_i <= 1'b1;
                end
            join_none
            wr(A_AMP, 8'hff);
            rdc(A_AMP, 8'hdf);
            wr(A_MOD, 8'hff);
            rdc(A_MOD, 8'hff);
            rst_i <= 1'b1;
            cyc(2);
            rst_i <= 1'b0;
        end
        for (int i = 0; i < 5; i++) begin
            for (int k = 0; k < 4; k++) begin
                i1 = k[0] & (styles[i] < 3'h4);
                i2 = ~k[0] & (styles[i] < 3'h4);
                carrier <= k[1];
                wr(A_DRV, {i2, i1, 2'b11, 1'b1, styles[i]});
                cyc(3);
                chk({30'h0, p1oe, p1oe & l1}, {30'h0, pin_exp(styles[i], k[1], i1)});
                chk({30'h0, p2oe, p2oe & l2}, {30'h0, pin_exp(styles[i], k[1], i2)});
            end
        end
        wr(A_DRV, 8'h02);
        cyc(3);
        chk({30'h0, p1oe, p2oe}, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(A_AMP, {k[1:0], 1'b1, 5'(k * 7 + 3)});
            cyc(3);
            chk({16'h0, mv}, {16'h0, red[k]});
            chk({27'h0, pct}, 32'(k * 7 + 3));
        end
        wr(A_MOD, 8'h08);
        cyc(3);
        chk({15'h0, maxl, mv}, 32'h0001_0000);
        for (int k = 0; k < 8; k++) begin
            pk = (k[1:0] == 2'h1) || (k[1:0] == 2'h2);
            wr(A_MOD, {5'h0, k[2:0]});
            env <= 1'b1;
            ext <= 1'b0;
            cyc(4);
            chk({31'h0, modulating}, {31'h0, pk & ((k[1:0] == 2'h1) ^ k[2])});
            env <= 1'b0;
            ext <= 1'b1;
            cyc(4);
            chk({31'h0, modulating}, {31'h0, pk & ((k[1:0] == 2'h2) ^ k[2])});
        end
        ext <= 1'b0;
        run <= 1'b1;
        for (int g = 0; g < 2; g++) begin
            wr(A_MOD, {lens[g], 4'h1});
            cyc(4);
            n = 0;
            do begin
                @(posedge ref_clk_i);
                n++;
            end while (!(carrier && !car_q) && n < 20);
            if (!(carrier && !car_q)) begin
                err_count++;
                end_of_test();
            end
            env <= 1'b1;
            cnt = 0;
            repeat (lens[g] * 8 + 40) begin
                @(posedge ref_clk_i);
                if (carrier && !car_q && guard === 1'b1) begin
                    cnt++;
                end
            end
            chk(32'(cnt), {28'h0, lens[g]});
            env <= 1'b0;
            cyc(4);
        end
        end_of_test();
    end
endmodule : testbench
